// *** logic/dec_event_counter_bank.sv ***
// diagnostic event counter bank with apb register access
// assumes event pulses are single pclk cycles from same-domain logic
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module dec_event_counter_bank #(
  parameter int CNT_W = dec_pkg::DEC_CNT_W,
  parameter int N_CNT = dec_pkg::DEC_NUM_CNT
) (
  // clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dec_pkg::DEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event pulses from the system event status
  input wire logic [N_CNT-1:0] evt,
  // interrupt
  output logic irq
);
  import dec_pkg::*;

  typedef struct packed {
    logic en;
    logic [N_CNT-1:0][CNT_W-1:0] cnt;
    logic [N_CNT-1:0] status;
    logic [N_CNT-1:0] mask;
    logic [31:0] rdata;
  } dec_state_t;

  dec_state_t s_r;
  dec_state_t s_nxt;
  logic [DEC_IDX_W-1:0] idx;
  logic [4:0] slot;
  logic mapped;
  logic setup;
  logic access;
  logic [N_CNT-1:0] rd_clr;
  logic [N_CNT-1:0] ev_set;

  // map a register index to its counter slot, or no slot
  function automatic logic [4:0] slot_of(input logic [DEC_IDX_W-1:0] i);
    logic [4:0] r;
    r = DEC_NO_SLOT;
    for (int k = 0; k < N_CNT; k++) begin
      if (DEC_CNT_IDX[k] == i) begin
        r = 5'(k);
      end
    end
    return r;
  endfunction

  // decode; low two address bits are ignored, words only
  assign idx = paddr[DEC_ADDR_W-1:2];
  assign slot = slot_of(idx);
  assign mapped = (slot != DEC_NO_SLOT) || (idx == DEC_IDX_CTRL) ||
                  (idx == DEC_IDX_STATUS) || (idx == DEC_IDX_MASK);
  assign setup = psel && !penable && ce;
  assign access = psel && penable && ce;

  // zero wait state; stalls while frozen, but a read set up while frozen returns the old prdata
  assign pready = psel && penable && ce;
  assign pslverr = pready && !mapped;
  assign prdata = s_r.rdata;
  assign irq = |(s_r.status & s_r.mask);

  always_comb begin
    s_nxt = s_r;
    rd_clr = '0;
    ev_set = '0;
    if (ce) begin
      // count only while enabled; natural wrap at all ones
      for (int k = 0; k < N_CNT; k++) begin
        if (s_r.en && evt[k]) begin
          s_nxt.cnt[k] = s_r.cnt[k] + 1'b1;
        end
      end
      ev_set = s_r.en ? evt : '0;
      // read data captured in setup so prdata comes from a flop
      if (setup && !pwrite) begin
        s_nxt.rdata = DEC_RDATA_RST;
        if (idx == DEC_IDX_CTRL) begin
          s_nxt.rdata[DEC_CTRL_EN_BIT] = s_r.en; // clear bit reads zero
        end else if (idx == DEC_IDX_STATUS) begin
          s_nxt.rdata[N_CNT-1:0] = s_r.status;
        end else if (idx == DEC_IDX_MASK) begin
          s_nxt.rdata[N_CNT-1:0] = s_r.mask;
        end else if (slot != DEC_NO_SLOT) begin
          // upper bits above the 12-bit counter read zero
          s_nxt.rdata[CNT_W-1:0] = s_r.cnt[slot];
        end
      end
      // completed read of status clears every bit set at access, shown or not
      if (access && !pwrite && idx == DEC_IDX_STATUS) begin
        rd_clr = s_r.status;
      end
      if (access && pwrite && idx == DEC_IDX_CTRL) begin
        // fields self-clear: only enable or clear can be asked for
        if (pwdata[DEC_CTRL_EN_BIT]) begin
          s_nxt.en = 1'b1;
        end else if (pwdata[DEC_CTRL_CLR_BIT]) begin
          // clear happens only with enable written zero; stops counting
          s_nxt.en = 1'b0;
          s_nxt.cnt = '0;
        end
      end
      if (access && pwrite && idx == DEC_IDX_MASK) begin
        s_nxt.mask = pwdata[N_CNT-1:0];
      end
      // a new event beats a read clear in the same cycle
      s_nxt.status = (s_r.status & ~rd_clr) | ev_set;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.en <= DEC_EN_RST;
      s_r.cnt <= '0;
      s_r.status <= '0;
      s_r.mask <= '0;
      s_r.rdata <= DEC_RDATA_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// *** logic/dec_pkg.sv ***
// constants shared by the diagnostic event counter bank
// assumes an apb master on pclk and event pulses from pclk logic
package dec_pkg;

  localparam int DEC_ADDR_W = 9;
  localparam int DEC_IDX_W = 7;
  localparam int DEC_NUM_CNT = 14;
  localparam int DEC_CNT_W = 12;

  // register indices; byte address is four times the index
  localparam logic [6:0] DEC_IDX_CTRL = 7'h00;
  localparam logic [6:0] DEC_IDX_HDR_ERR = 7'h04;
  localparam logic [6:0] DEC_IDX_SYNC_LOSS = 7'h06;
  localparam logic [6:0] DEC_IDX_FCS_GOOD = 7'h08;
  localparam logic [6:0] DEC_IDX_FCS_ERR = 7'h0a;
  localparam logic [6:0] DEC_IDX_FILT_REJ = 7'h0c;
  localparam logic [6:0] DEC_IDX_RX_OVR = 7'h0e;
  localparam logic [6:0] DEC_IDX_SFD_TO = 7'h10;
  localparam logic [6:0] DEC_IDX_PRE_TO = 7'h12;
  localparam logic [6:0] DEC_IDX_FWAIT_TO = 7'h14;
  localparam logic [6:0] DEC_IDX_TX_SENT = 7'h16;
  localparam logic [6:0] DEC_IDX_HALF_PER = 7'h18;
  localparam logic [6:0] DEC_IDX_WR_CRC = 7'h1a;
  localparam logic [6:0] DEC_IDX_SEQ_QUAL = 7'h28;
  localparam logic [6:0] DEC_IDX_LOW_VOLT = 7'h2a;
  localparam logic [6:0] DEC_IDX_STATUS = 7'h40;
  localparam logic [6:0] DEC_IDX_MASK = 7'h41;

  // counter slot n holds the event on event input bit n
  localparam logic [6:0] DEC_CNT_IDX [DEC_NUM_CNT] = '{
    DEC_IDX_HDR_ERR, DEC_IDX_SYNC_LOSS, DEC_IDX_FCS_GOOD,
    DEC_IDX_FCS_ERR, DEC_IDX_FILT_REJ, DEC_IDX_RX_OVR,
    DEC_IDX_SFD_TO, DEC_IDX_PRE_TO, DEC_IDX_FWAIT_TO,
    DEC_IDX_TX_SENT, DEC_IDX_HALF_PER,
    DEC_IDX_WR_CRC,
    DEC_IDX_SEQ_QUAL, DEC_IDX_LOW_VOLT};
  localparam logic [4:0] DEC_NO_SLOT = 5'h1f;

  // control fields and reset values
  localparam int DEC_CTRL_EN_BIT = 0;
  localparam int DEC_CTRL_CLR_BIT = 1;
  localparam logic DEC_EN_RST = 1'b0;
  localparam logic [31:0] DEC_RDATA_RST = 32'h0000_0000;

endpackage

// *** test/dec_chk.sv ***
// checks on the counter bank apb port and irq
// sees top ports only; bound in below
`timescale 1ns/10ps
`default_nettype none
module dec_chk import dec_pkg::*; #(parameter int CNT_W = 12, N_CNT = 14) (
  // apb, events, interrupt
  input wire logic pclk, presetn, ce, psel, penable, pwrite, pready,
  input wire logic pslverr, irq,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [N_CNT-1:0] evt
);
  // read setup and word index
  wire rd = psel && !penable && ce && !pwrite;
  wire [6:0] ix = paddr[8:2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_a: assert property (pready == (psel && penable && ce))
    else $error("pready wrong");
  unmap_a: assert property (pready && ix == 7'h05 |-> pslverr)
    else $error("no slave error");
  map_a:
    assert property (pready && ix inside {DEC_CNT_IDX} |-> !pslverr)
    else $error("counter refused");
  wid_a:
    assert property (rd && ix inside {DEC_CNT_IDX} |=> prdata[31:CNT_W] == 0)
    else $error("counter high bits set");
  ctl_a: assert property (rd && ix == 7'h00 |=> prdata[31:1] == 0)
    else $error("control reserved bits set");
  hold_a: assert property (!rd |=> $stable(prdata))
    else $error("prdata moved");
  up_a: assert property ($rose(irq) |-> $past(|evt || pready && pwrite))
    else $error("irq rose without cause");
  dn_a: assert property ($fell(irq) |-> $past(pready))
    else $error("irq fell without access");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (rd && ix == 7'h04 ##1 prdata[11:0] != 0);
endmodule
bind dec_event_counter_bank dec_chk #(.CNT_W(CNT_W), .N_CNT(N_CNT))
  chk_u (.*);
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the counter bank over apb
// drives all input ports; a monitor compares queued read results
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dec_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, irq, en = 0;
  logic [13:0] evt = 14'h0000, st = 14'h0000;
  logic [11:0] cnt [14] = '{default: 0};
  logic [31:0] exp_q [$];
  int err_count = 0, n_checks = 0, seed = 62;
  always #20 pclk = ~pclk;
  dec_event_counter_bank dut_u (.*);
  task chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one apb transfer; for reads d is the expected word
  task xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
    // idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  // pulse events, idle cycle after so pulses never merge
  task ev(input logic [13:0] m);
    evt <= m;
    @(posedge pclk);
    evt <= 14'h0000;
    @(posedge pclk);
    if (en) st |= m;
    if (en) for (int i = 0; i < 14; i++) cnt[i] += 12'(m[i]);
  endtask
  task rd_all;
    for (int i = 0; i < 14; i++)
      xfer(0, {DEC_CNT_IDX[i], 2'b00}, {20'h0_0000, cnt[i]});
  endtask
  task ck_irq(input logic e);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask
  // monitor: each completed read takes the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("prdata", prdata, exp_q.pop_front());
  initial begin
    #400000;
    err_count++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 9'h000, 32'h0000_0000);
    rd_all;
    ev(14'h3fff);
    xfer(1, 9'h000, 32'h0000_0001);
    en = 1;
    repeat (20) ev(14'($random(seed)));
    xfer(1, 9'h000, 32'h0000_0000);
    xfer(1, 9'h000, 32'h0000_0003);
    xfer(1, 9'h010, 32'h0000_0fff);
    repeat (20) ev(14'($random(seed)));
    rd_all;
    xfer(0, 9'h000, 32'h0000_0001);
    // held high: 4097 counts wrap to plus one
    evt <= 14'h0001;
    repeat (4097) @(posedge pclk);
    evt <= 14'h0000;
    cnt[0] += 12'h001;
    st[0] = 1'b1;
    @(posedge pclk);
    // frozen: this event must not count
    ce <= 0;
    evt <= 14'h0001;
    @(posedge pclk);
    ce <= 1;
    evt <= 14'h0000;
    rd_all;
    xfer(0, 9'h014, 32'h0000_0000);
    xfer(1, {DEC_IDX_MASK, 2'b00}, 32'h0000_0001);
    ck_irq(1);
    xfer(0, {DEC_IDX_STATUS, 2'b00}, {18'h0_0000, st});
    st = 14'h0000;
    ck_irq(0);
    ev(14'h0002);
    ck_irq(0);
    ev(14'h0001);
    ck_irq(1);
    xfer(1, 9'h000, 32'h0000_0002);
    en = 0;
    cnt = '{default: 0};
    ev(14'h3fff);
    rd_all;
    close_out;
  end
endmodule
`default_nettype wire
